// ### rtl/tsalrt_core.v
// two-wire slave front end: address match, ack, read data shift and alert pin
`timescale 1ns/100ps
`include "tsalrt_defines.vh"

// Function
// RQ1 - data bits sampled on each detected rising serial clock edge
// RQ2 - read data changes only after a falling serial clock edge
// RQ3 - data line only pulled low or released, never driven high
// RQ4 - master keeps serial clock high while bus is idle
// RQ5 - alert asserts when temperature leaves the high and low limits
// RQ6 - alert_mode_select picks interrupt or comparator behaviour
// RQ7 - alert active low after reset; alert_polarity_select makes it active high
// RQ8 - host keeps shared alert lines active low
// RQ9 - host may query the alert response address to find the alerter
// RQ10 - three low address bits come from address_strap_pins
// RQ11 - floating strap pins read as zero
// RQ12 - upper four address bits are the fixed type identifier per function
// RQ13 - direction bit after address: one reads, zero writes
// RQ14 - matching address acknowledged, mismatch not acknowledged and returns idle
// RQ15 - acknowledge holds data low across the whole ninth clock
// RQ16 - clock edges, start and stop found by sampling, state follows them
module tsalrt_core (
    input  wire       i_clock,
    input  wire       i_sys_rst,
    input  wire       i_scl,
    input  wire       i_sda,
    input  wire [2:0] i_address_strap_pins,
    input  wire       i_alert_mode_select,
    input  wire       i_alert_polarity_select,
    input  wire       i_temp_above_high,
    input  wire       i_temp_below_low,
    input  wire       i_alert_clear,
    input  wire [7:0] i_read_data,
    output reg        o_sda_out,
    output reg        o_sda_oe_n,
    output reg        o_alert_out,
    output reg        o_alert_oe_n,
    output reg        o_addr_hit,
    output reg        o_sensor_sel,
    output reg        o_read_dir,
    output reg        o_byte_valid,
    output reg  [7:0] o_byte_data,
    output reg        o_read_req
);
    // ****************************************
    // pin synchronisers
    // ****************************************
    wire scl_s;
    wire sda_s;
    wire [2:0] strap_s;
    tsalrt_sync #(.RST_VAL(1'b1)) u_scl (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
        .i_async(i_scl), .o_sync(scl_s));
    tsalrt_sync #(.RST_VAL(1'b1)) u_sda (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
        .i_async(i_sda), .o_sync(sda_s));
    tsalrt_sync #(.RST_VAL(1'b0)) u_a0 (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
        .i_async(i_address_strap_pins[0]), .o_sync(strap_s[0]));
    tsalrt_sync #(.RST_VAL(1'b0)) u_a1 (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
        .i_async(i_address_strap_pins[1]), .o_sync(strap_s[1]));
    tsalrt_sync #(.RST_VAL(1'b0)) u_a2 (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
        .i_async(i_address_strap_pins[2]), .o_sync(strap_s[2]));

    // ****************************************
    // edge and condition detection
    // ****************************************
    reg  scl_d_ff;
    reg  sda_d_ff;
    wire scl_rise = scl_s & ~scl_d_ff;
    wire scl_fall = ~scl_s & scl_d_ff;
    wire start_c  = scl_s & scl_d_ff & sda_d_ff & ~sda_s;   // RQ16
    wire stop_c   = scl_s & scl_d_ff & ~sda_d_ff & sda_s;   // RQ16

    localparam [3:0] ST_IDLE = 4'b0001;
    localparam [3:0] ST_ADDR = 4'b0010;
    localparam [3:0] ST_WR   = 4'b0100;
    localparam [3:0] ST_RD   = 4'b1000;

    reg [3:0] state_ff;
    reg [3:0] nxt_state;
    reg [3:0] bit_cnt_ff;
    reg [7:0] shift_ff;
    reg [7:0] tx_ff;
    reg       ack_phase_ff;
    reg       master_nack_ff;
    reg       alert_act_ff;
    reg [3:0] strap_cap_ff;     // [3] marks captured

    reg [1:0] strap_age_ff;     // edges since reset release

    // straps caught once after reset release; pull-downs give zero when open
    // the wait lets the synchronisers drop their reset value first
    always @(posedge i_clock) begin
        if (i_sys_rst) begin
            strap_cap_ff <= 4'h0;
            strap_age_ff <= 2'h0;
        end else if (strap_age_ff != `TSALRT_STRAP_WAIT) begin
            strap_age_ff <= strap_age_ff + 2'h1;
        end else if (!strap_cap_ff[3]) begin
            strap_cap_ff <= {1'b1, strap_s};   // RQ10 RQ11
        end
    end

    wire [6:0] addr_sens = {`TSALRT_TYPE_SENSOR, strap_cap_ff[2:0]};   // RQ12
    wire [6:0] addr_mem  = {`TSALRT_TYPE_MEMORY, strap_cap_ff[2:0]};   // RQ12
    wire [7:0] rx_byte   = {shift_ff[6:0], sda_s};
    wire hit_s   = rx_byte[7:1] == addr_sens;
    wire hit_m   = rx_byte[7:1] == addr_mem;
    wire hit_ara = (rx_byte[7:1] == `TSALRT_ARA_ADDR) && alert_act_ff && rx_byte[0];
    // alert response returns the own address, else the supplied read data
    wire       ara_sel = o_addr_hit && o_sensor_sel && (shift_ff[7:1] == `TSALRT_ARA_ADDR);
    wire [7:0] tx_load = ara_sel ? {addr_sens, 1'b1} : i_read_data;   // RQ9

    // ****************************************
    // protocol state machine
    // ****************************************
    always @* begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE: nxt_state = ST_IDLE;
            ST_ADDR: begin
                if (scl_fall && ack_phase_ff && !o_addr_hit) begin
                    nxt_state = ST_IDLE;           // RQ14
                end else if (scl_fall && ack_phase_ff) begin
                    nxt_state = o_read_dir ? ST_RD : ST_WR;   // RQ13
                end
            end
            ST_WR:   nxt_state = ST_WR;
            ST_RD: begin
                if (scl_fall && ack_phase_ff && master_nack_ff) begin
                    nxt_state = ST_IDLE;
                end
            end
            default: nxt_state = ST_IDLE;
        endcase
        if (start_c) begin
            nxt_state = ST_ADDR;
        end else if (stop_c) begin
            nxt_state = ST_IDLE;
        end
    end

    // bit counting and data line control, all on detected edges
    always @(posedge i_clock) begin
        if (i_sys_rst) begin
            scl_d_ff       <= 1'b1;
            sda_d_ff       <= 1'b1;
            state_ff       <= ST_IDLE;
            bit_cnt_ff     <= 4'h0;
            shift_ff       <= 8'h00;
            tx_ff          <= 8'h00;
            ack_phase_ff   <= 1'b0;
            master_nack_ff <= 1'b0;
            o_sda_out      <= 1'b0;
            o_sda_oe_n     <= 1'b1;
            o_addr_hit     <= 1'b0;
            o_sensor_sel   <= 1'b0;
            o_read_dir     <= 1'b0;
            o_byte_valid   <= 1'b0;
            o_byte_data    <= 8'h00;
            o_read_req     <= 1'b0;
        end else begin
            scl_d_ff     <= scl_s;
            sda_d_ff     <= sda_s;
            state_ff     <= nxt_state;
            o_sda_out    <= 1'b0;                // RQ3
            o_byte_valid <= 1'b0;
            o_read_req   <= 1'b0;
            if (start_c || stop_c) begin
                // the start's own clock fall wraps this to bit 0
                bit_cnt_ff   <= `TSALRT_PRE_BIT;
                ack_phase_ff <= 1'b0;
                o_sda_oe_n   <= 1'b1;
                o_addr_hit   <= 1'b0;
            end else if (scl_rise && state_ff != ST_IDLE) begin
                if (bit_cnt_ff == `TSALRT_ACK_BIT) begin
                    master_nack_ff <= sda_s;
                end else begin
                    shift_ff <= rx_byte;        // RQ1
                end
                if (bit_cnt_ff == `TSALRT_LAST_BIT && state_ff == ST_ADDR) begin
                    o_addr_hit   <= hit_s | hit_m | hit_ara;
                    o_sensor_sel <= hit_s | hit_ara;
                    o_read_dir   <= rx_byte[`TSALRT_BIT_RW];
                    o_read_req   <= (hit_s | hit_m) & rx_byte[`TSALRT_BIT_RW];
                end
                if (bit_cnt_ff == `TSALRT_LAST_BIT && state_ff == ST_WR) begin
                    o_byte_valid <= 1'b1;
                    o_byte_data  <= rx_byte;
                end
            end else if (scl_fall && state_ff != ST_IDLE) begin
                // the data line moves only here, or is released at start and stop, so it settles before the next rise
                if (bit_cnt_ff == `TSALRT_ACK_BIT) begin
                    bit_cnt_ff   <= 4'h0;
                    ack_phase_ff <= 1'b0;
                    if (nxt_state == ST_RD) begin
                        tx_ff      <= tx_load;
                        o_sda_oe_n <= tx_load[7];   // RQ2
                    end else begin
                        o_sda_oe_n <= 1'b1;
                    end
                end else if (bit_cnt_ff == `TSALRT_LAST_BIT) begin
                    bit_cnt_ff   <= `TSALRT_ACK_BIT;
                    ack_phase_ff <= 1'b1;
                    // ack holds low over the full ninth clock
                    o_sda_oe_n   <= (state_ff == ST_RD) ? 1'b1 :
                                    (state_ff == ST_ADDR) ? ~o_addr_hit : 1'b0;   // RQ15 RQ14
                end else begin
                    bit_cnt_ff <= bit_cnt_ff + 4'h1;
                    if (state_ff == ST_RD) begin
                        o_sda_oe_n <= tx_ff[6];     // RQ2 RQ3
                        tx_ff      <= {tx_ff[6:0], 1'b1};
                    end else begin
                        o_sda_oe_n <= 1'b1;
                    end
                end
            end
        end
    end

    // ****************************************
    // alert output
    // ****************************************
    wire out_of_lim = i_temp_above_high | i_temp_below_low;   // RQ5
    always @(posedge i_clock) begin
        if (i_sys_rst) begin
            alert_act_ff <= 1'b0;
            o_alert_out  <= 1'b0;
            o_alert_oe_n <= 1'b1;                 // inactive low-polarity = released
        end else begin
            if (i_alert_mode_select) begin
                // interrupt: sticky, event wins over a clear in the same cycle
                if (out_of_lim) begin
                    alert_act_ff <= 1'b1;         // RQ6
                end else if (i_alert_clear || (ara_sel && state_ff == ST_RD)) begin
                    alert_act_ff <= 1'b0;
                end
            end else begin
                alert_act_ff <= out_of_lim;       // RQ6
            end
            o_alert_out  <= 1'b0;
            // open drain: pulled low when the asserted level is low
            o_alert_oe_n <= ~(alert_act_ff ^ i_alert_polarity_select);   // RQ7
        end
    end
endmodule

// ### rtl/tsalrt_defines.vh
// shared constants for the sensor bus pin and alert logic
`ifndef TSALRT_DEFINES_VH
`define TSALRT_DEFINES_VH
`define TSALRT_TYPE_SENSOR   4'h5    // type identifier, value arbitrary
`define TSALRT_TYPE_MEMORY   4'h3    // type identifier, value arbitrary
`define TSALRT_ARA_ADDR      7'h0C
`define TSALRT_BIT_RW        0
`define TSALRT_ACK_BIT       4'h8
`define TSALRT_LAST_BIT      4'h7
`define TSALRT_SYNC_RST      1'b1
`define TSALRT_PRE_BIT       4'hF
`define TSALRT_STRAP_WAIT    2'h2
`endif

// ### rtl/tsalrt_sync.v
// two-flop synchroniser for pins from outside the clock domain
`timescale 1ns/100ps
module tsalrt_sync #(
    parameter RST_VAL = 1'b1
) (
    input  wire i_clock,
    input  wire i_sys_rst,
    input  wire i_async,
    output wire o_sync
);
    reg meta_ff;
    reg sync_ff;
    // first stage only feeds the second stage
    always @(posedge i_clock) begin
        if (i_sys_rst) begin
            meta_ff <= RST_VAL;
            sync_ff <= RST_VAL;
        end else begin
            meta_ff <= i_async;
            sync_ff <= meta_ff;
        end
    end
    assign o_sync = sync_ff;
endmodule

// ### tb/tsalrt_core_sva.sv
// checker of the pin and alert rules of the sensor bus core
`timescale 1ns/100ps
module tsalrt_core_chk (
    input wire i_clock,
    input wire i_sys_rst,
    input wire i_scl,
    input wire i_alert_mode_select,
    input wire i_alert_polarity_select,
    input wire i_temp_above_high,
    input wire i_temp_below_low,
    input wire o_sda_out,
    input wire o_sda_oe_n,
    input wire o_alert_out,
    input wire o_alert_oe_n,
    input wire o_addr_hit,
    input wire o_read_dir,
    input wire o_byte_valid,
    input wire o_read_req
);
    // ****************
    // helper and rules
    // ****************
    reg [3:0] hi_run_ff;
    // cycles of raw scl high; saturates so a long idle never wraps to zero
    always @(posedge i_clock) begin
        if (i_sys_rst) begin
            hi_run_ff <= 4'h0;
        end else begin
            hi_run_ff <= !i_scl ? 4'h0 : (hi_run_ff == 4'hF) ? 4'hF : hi_run_ff + 4'h1;
        end
    end
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_sys_rst);
    wire cmp_lo = !i_alert_mode_select && !i_alert_polarity_select;
    wire in_lim = !i_temp_above_high && !i_temp_below_low;
    property p_sda_no_high; o_sda_out == 1'b0; endproperty
    a_sda_no_high: assert property (p_sda_no_high) else $error("sda driven high");
    property p_alert_od; o_alert_out == 1'b0; endproperty
    a_alert_od: assert property (p_alert_od) else $error("alert driven high");
    property p_oe_low_phase; $changed(o_sda_oe_n) |-> hi_run_ff < 4'h6; endproperty
    a_oe_low_phase: assert property (p_oe_low_phase) else $error("sda moved in high");
    property p_ack_hold; $fell(o_sda_oe_n) |-> (!o_sda_oe_n) [*6]; endproperty
    a_ack_hold: assert property (p_ack_hold) else $error("low pull too short");
    property p_rst_idle; disable iff (1'b0) i_sys_rst |=> o_sda_oe_n && o_alert_oe_n; endproperty
    a_rst_idle: assert property (p_rst_idle) else $error("pins not released");
    property p_cmp_set; (cmp_lo && i_temp_above_high) [*4] |-> !o_alert_oe_n; endproperty
    a_cmp_set: assert property (p_cmp_set) else $error("alert not active");
    property p_cmp_clr; (cmp_lo && in_lim) [*4] |-> o_alert_oe_n; endproperty
    a_cmp_clr: assert property (p_cmp_clr) else $error("alert not idle");
    property p_pol_hi;
        (i_alert_polarity_select && !i_alert_mode_select && in_lim) [*4] |-> !o_alert_oe_n;
    endproperty
    a_pol_hi: assert property (p_pol_hi) else $error("inverted idle wrong");
    property p_wr_byte; o_byte_valid |-> o_addr_hit && !o_read_dir; endproperty
    a_wr_byte: assert property (p_wr_byte) else $error("byte without write hit");
    property p_rd_req; o_read_req |-> ##[0:2] (o_addr_hit && o_read_dir); endproperty
    a_rd_req: assert property (p_rd_req) else $error("read without hit");
endmodule
bind tsalrt_core tsalrt_core_chk u_chk (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
    .i_scl(i_scl), .i_alert_mode_select(i_alert_mode_select),
    .i_alert_polarity_select(i_alert_polarity_select), .i_temp_above_high(i_temp_above_high),
    .i_temp_below_low(i_temp_below_low), .o_sda_out(o_sda_out), .o_sda_oe_n(o_sda_oe_n),
    .o_alert_out(o_alert_out), .o_alert_oe_n(o_alert_oe_n), .o_addr_hit(o_addr_hit),
    .o_read_dir(o_read_dir), .o_byte_valid(o_byte_valid), .o_read_req(o_read_req));

// ### tb/tsalrt_bus_master.sv
// behavioural two-wire bus master, 160 ns serial clock
`timescale 1ns/100ps
module tsalrt_bus_master (
    output reg  o_scl,
    output reg  o_sda_rel,
    input  wire i_sda
);
    // *************
    // bus sequences
    // *************
    initial begin
        o_scl = 1'b1;
        o_sda_rel = 1'b1;
    end
    // data set early in the low phase, sampled mid high so slow answers still land
    task bit_cyc(input b, output s);
        begin
            o_sda_rel = b;
            #60 o_scl = 1'b1;
            #40 s = i_sda;
            #40 o_scl = 1'b0;
            #20;
        end
    endtask
    task bus_start;
        begin
            #80 o_sda_rel = 1'b0;
            #80 o_scl = 1'b0;
        end
    endtask
    // clock left high afterwards: it stands still between frames
    task bus_stop;
        begin
            o_sda_rel = 1'b0;
            #60 o_scl = 1'b1;
            #80 o_sda_rel = 1'b1;
            #80;
        end
    endtask
    task xfer(input [7:0] tx, input ack_in, output [7:0] rx, output ack_seen);
        integer i;
        reg     s;
        begin
            for (i = 7; i >= 0; i = i - 1) begin
                bit_cyc(tx[i], s);
                rx[i] = s;
            end
            bit_cyc(ack_in, ack_seen);
        end
    endtask
endmodule

// ### tb/tsalrt_core_test.sv
// self-checking bench of the sensor bus core
`timescale 1ns/100ps
`include "tsalrt_defines.vh"
module tsalrt_core_test;
    reg        i_clock;
    reg        i_sys_rst;
    reg  [2:0] straps;
    reg        mode, alert_polarity_select, above, below, clr;
    reg  [7:0] rdata, rx, last_byte, rreq_cnt;
    reg        ack;
    wire       sda_out, sda_oe_n, al_out, al_oe_n, hit, sens, rdir, bval, rreq;
    wire [7:0] bdata;
    wire       scl, m_rel;
    integer    miscompares, checked;
    // pull-ups: a released line reads high
    wire sda = m_rel & (sda_oe_n | sda_out);
    wire alert_line = al_oe_n | al_out;
    tsalrt_core dut (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_scl(scl), .i_sda(sda),
        .i_address_strap_pins(straps), .i_alert_mode_select(mode),
        .i_alert_polarity_select(alert_polarity_select), .i_temp_above_high(above), .i_temp_below_low(below),
        .i_alert_clear(clr), .i_read_data(rdata), .o_sda_out(sda_out), .o_sda_oe_n(sda_oe_n),
        .o_alert_out(al_out), .o_alert_oe_n(al_oe_n), .o_addr_hit(hit), .o_sensor_sel(sens),
        .o_read_dir(rdir), .o_byte_valid(bval), .o_byte_data(bdata), .o_read_req(rreq));
    tsalrt_bus_master bus (.o_scl(scl), .o_sda_rel(m_rel), .i_sda(sda));
    initial begin
        i_clock = 1'b0;
        forever #10 i_clock = ~i_clock;
    end
    // keep the last write byte; the valid flag lasts one cycle only
    always @(posedge i_clock) begin
        if (i_sys_rst) begin
            last_byte <= 8'h00;
        end else if (bval === 1'b1) begin
            last_byte <= bdata;
        end
    end
    // read requests are one-cycle pulses, so count them
    always @(posedge i_clock) begin
        if (i_sys_rst) begin
            rreq_cnt <= 8'h00;
        end else if (rreq === 1'b1) begin
            rreq_cnt <= rreq_cnt + 8'h01;
        end
    end
    // ****************
    // checks and tasks
    // ****************
    task check(input [7:0] seen, input [7:0] exp);
        begin
            checked = checked + 1;
            if (seen !== exp) begin
                miscompares = miscompares + 1;
                $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task complete_run;
        begin
            $display("miscompares=%0d checked=%0d", miscompares, checked);
            if (miscompares == 0 && checked > 0) $display("RESULT: PASS");
            else $display("RESULT: FAIL");
            $finish;
        end
    endtask
    task set_al(input m, input p, input a, input b);
        begin
            @(posedge i_clock) #1;
            {mode, alert_polarity_select, above, below} = {m, p, a, b};
        end
    endtask
    task wait_al(input exp);
        integer n;
        begin
            for (n = 0; n < 20 && alert_line !== exp; n = n + 1) begin
                @(posedge i_clock);
                #1;
            end
            check(alert_line, exp);
            if (alert_line !== exp) complete_run;
        end
    endtask
    task addr_byte(input [6:0] a, input rd, input exp_ack);
        begin
            // pins move just after a clock edge, never on it
            @(posedge i_clock) #1;
            bus.bus_start;
            bus.xfer({a, rd}, 1'b1, rx, ack);
            check(ack, exp_ack);
        end
    endtask
    task t_write;
        begin
            addr_byte({`TSALRT_TYPE_SENSOR, straps}, 1'b0, 1'b0);
            check(sens, 1'b1);
            check(hit, 1'b1);
            bus.xfer(8'hA5, 1'b1, rx, ack);
            check(ack, 1'b0);
            check(last_byte, 8'hA5);
            bus.bus_stop;
        end
    endtask
    task t_read;
        begin
            addr_byte({`TSALRT_TYPE_SENSOR, straps}, 1'b1, 1'b0);
            check(rdir, 1'b1);
            check(rreq_cnt, 8'h01);
            bus.xfer(8'hFF, 1'b1, rx, ack);
            check(rx, 8'h3C);
            bus.bus_stop;
            addr_byte({`TSALRT_TYPE_MEMORY, straps}, 1'b0, 1'b0);
            check(sens, 1'b0);
            bus.bus_stop;
            addr_byte({`TSALRT_TYPE_SENSOR, straps ^ 3'h1}, 1'b0, 1'b1);
            check(hit, 1'b0);
            bus.bus_stop;
        end
    endtask
    task t_alert;
        begin
            set_al(0, 0, 1, 0);
            wait_al(1'b0);
            set_al(0, 0, 0, 1);
            wait_al(1'b0);
            set_al(0, 0, 0, 0);
            wait_al(1'b1);
            set_al(0, 1, 0, 0);
            wait_al(1'b0);
            set_al(0, 1, 1, 0);
            wait_al(1'b1);
            set_al(1, 0, 1, 0);
            wait_al(1'b0);
            set_al(1, 0, 0, 0);
            repeat (8) @(posedge i_clock);
            #1;
            check(alert_line, 1'b0);
            addr_byte(`TSALRT_ARA_ADDR, 1'b1, 1'b0);
            bus.xfer(8'hFF, 1'b1, rx, ack);
            check(rx[7:1], {`TSALRT_TYPE_SENSOR, straps});
            bus.bus_stop;
            wait_al(1'b1);
            set_al(1, 0, 1, 0);
            wait_al(1'b0);
            set_al(1, 0, 0, 0);
            clr = 1'b1;
            @(posedge i_clock) #1 clr = 1'b0;
            wait_al(1'b1);
        end
    endtask
    // mid-run reset with the straps driven to zero, as pull-downs would hold open pins
    task t_strap;
        begin
            @(posedge i_clock) #1;
            straps = 3'h0;
            i_sys_rst = 1'b1;
            repeat (2) @(posedge i_clock);
            #1 i_sys_rst = 1'b0;
            repeat (5) @(posedge i_clock);
            addr_byte({`TSALRT_TYPE_SENSOR, 3'h0}, 1'b0, 1'b0);
            check(hit, 1'b1);
            bus.bus_stop;
        end
    endtask
    initial begin
        miscompares = 0;
        checked = 0;
        {i_sys_rst, straps, mode, alert_polarity_select, above, below, clr} = {1'b1, 3'h5, 5'h00};
        rdata = 8'h3C;
        repeat (2) @(posedge i_clock);
        #1 i_sys_rst = 1'b0;
        repeat (5) @(posedge i_clock);
        t_write;
        t_read;
        t_alert;
        t_strap;
        complete_run;
    end
endmodule
